// *** rtl/lvr_pkg.sv ***
// package: register map, field layout and shared types of the ladder reference control
package lvr_pkg;
   localparam logic [7:0] LVR_ADDR_PORT_A_DIRECTION = 8'h85;
   localparam logic [7:0] LVR_ADDR_REFERENCE_CONTROL = 8'h9F;
   localparam logic [7:0] LVR_ADDR_COMPARATOR_CONTROL = 8'h1F;
   localparam logic [7:0] LVR_RESET_PORT_A_DIRECTION = 8'h1F;
   localparam logic [7:0] LVR_RESET_REFERENCE_CONTROL = 8'h00;
   localparam logic [7:0] LVR_RESET_COMPARATOR_CONTROL = 8'h00;
   localparam logic [7:0] LVR_MASK_PORT_A_DIRECTION = 8'h1F;
   localparam logic [7:0] LVR_MASK_REFERENCE_CONTROL = 8'hEF;
   localparam logic [7:0] LVR_MASK_COMPARATOR_CONTROL = 8'h0F;
   localparam int LVR_POS_POWER = 7;
   localparam int LVR_POS_PIN = 6;
   localparam int LVR_POS_RANGE = 5;
   localparam int LVR_POS_SHARED_PIN = 2;
   localparam logic [2:0] LVR_CMP_MODE_INTERNAL = 3'h2;
   localparam int LVR_TAPS = 16;
   localparam int LVR_LOW_DIV = 24;
   localparam int LVR_HIGH_DIV = 32;
   localparam int LVR_HIGH_BASE = 8;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } lvr_bus_req_type;

   typedef struct packed {
      logic power_on;
      logic pin_route;
      logic range_low;
      logic [15:0] tap_onehot;
      logic [5:0] level_num;
      logic [5:0] level_den;
      logic cmp_plus_internal;
   } lvr_analog_ctrl_type;
endpackage

// *** rtl/lvr_tap_decode.sv ***
// one-hot tap select and output ratio for the ladder
`timescale 1ns/100ps
`default_nettype none
module lvr_tap_decode
   import lvr_pkg::*;
#(
   parameter int TAPS = LVR_TAPS
) (
   input wire logic enable,
   input wire logic range_low,
   input wire logic [3:0] tap_select,
   output logic [TAPS-1:0] tap_onehot,
   output logic [5:0] level_num,
   output logic [5:0] level_den
);
   // one-hot per tap, all low while the ladder is off
   genvar g;
   generate
      for (g = 0; g < TAPS; g++) begin : gen_tap
         assign tap_onehot[g] = enable && (tap_select == 4'(g)); // [RULE5] [RULE14]
      end
   endgenerate

   // low range: n/24; high range: (8+n)/32, i.e. 1/4 + n/32
   always_comb begin
      if (range_low) begin
         level_num = {2'h0, tap_select}; // [RULE6]
         level_den = 6'(LVR_LOW_DIV);
      end else begin
         level_num = 6'(LVR_HIGH_BASE) + {2'h0, tap_select}; // [RULE7]
         level_den = 6'(LVR_HIGH_DIV);
      end
   end
endmodule
`default_nettype wire

// *** rtl/lvr_ladder_ctrl.sv ***
// top: register file and control of the ladder voltage reference
// Notes on behaviour
// RULE1 - top bit powers ladder on or off
// RULE2 - bit six routes reference to pin
// RULE3 - bit five one low, zero high range
// RULE4 - bit four ignores writes, reads zero
// RULE5 - low nibble selects one of sixteen taps
// RULE6 - low range output is n/24 supply
// RULE7 - high range is quarter plus n/32
// RULE8 - reset clears every reference control field
// RULE9 - sleep wake leaves control register unchanged
// RULE10 - software should power down before sleep
// RULE11 - pin driven only if input and enabled
// RULE12 - comparator writes never touch reference control
// RULE13 - comparator mode 010 routes reference inward
// RULE14 - powered down: no tap, no pin route
`timescale 1ns/100ps
`default_nettype none
module lvr_ladder_ctrl
   import lvr_pkg::*;
#(
   parameter int TAPS = LVR_TAPS
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic sleep_wake,
   output logic ladder_power_on,
   output logic ref_to_pin_enable,
   output logic range_low_select,
   output logic [3:0] tap_select,
   output logic [TAPS-1:0] tap_onehot,
   output logic [5:0] level_num,
   output logic [5:0] level_den,
   output logic shared_analog_pin_route,
   output logic shared_pin_direction,
   output logic comparator_plus_internal,
   output logic [2:0] comparator_mode_field
);
   typedef struct packed {
      logic [7:0] reference_control;
      logic [7:0] port_a_direction;
      logic [7:0] comparator_control;
      logic [7:0] rdata;
      logic route;
      logic cmp_internal;
   } lvr_state_type;

   typedef enum logic [1:0] {
      SEL_NONE,
      SEL_REFERENCE,
      SEL_DIRECTION,
      SEL_COMPARATOR
   } lvr_sel_type;

   lvr_state_type state;
   lvr_state_type next_state;
   lvr_bus_req_type req;
   lvr_sel_type sel;
   lvr_analog_ctrl_type ana;
   logic [TAPS-1:0] dec_onehot;
   logic [5:0] dec_num;
   logic [5:0] dec_den;

   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   // which mapped register an address hits; one decoder serves reads and writes alike
   function automatic lvr_sel_type decode_addr(input logic [7:0] a);
      lvr_sel_type k;
      k = SEL_NONE;
      if (a == LVR_ADDR_REFERENCE_CONTROL) begin
         k = SEL_REFERENCE;
      end else if (a == LVR_ADDR_PORT_A_DIRECTION) begin
         k = SEL_DIRECTION;
      end else if (a == LVR_ADDR_COMPARATOR_CONTROL) begin
         k = SEL_COMPARATOR;
      end
      return k;
   endfunction

   assign sel = decode_addr(req.addr);

   // read value of one mapped register, zero elsewhere
   function automatic logic [7:0] read_reg(input lvr_state_type s, input lvr_sel_type k);
      logic [7:0] v;
      v = 8'h00;
      if (k == SEL_REFERENCE) begin
         v = s.reference_control & LVR_MASK_REFERENCE_CONTROL; // [RULE4]
      end else if (k == SEL_DIRECTION) begin
         v = s.port_a_direction & LVR_MASK_PORT_A_DIRECTION;
      end else if (k == SEL_COMPARATOR) begin
         v = s.comparator_control & LVR_MASK_COMPARATOR_CONTROL;
      end
      return v;
   endfunction

   always_comb begin
      next_state = state;
      next_state.rdata = 8'h00;
      if (req.rd) begin
         next_state.rdata = read_reg(state, sel);
      end
      // sleep_wake is deliberately unused by the register path: a wake is
      // resumption, not a reset, so all fields hold their value
      if (req.wr) begin
         if (sel == SEL_REFERENCE) begin
            next_state.reference_control = req.wdata & LVR_MASK_REFERENCE_CONTROL; // [RULE4]
         end else if (sel == SEL_DIRECTION) begin
            next_state.port_a_direction = req.wdata & LVR_MASK_PORT_A_DIRECTION;
         end else if (sel == SEL_COMPARATOR) begin
            // comparator writes stay in their own register
            next_state.comparator_control = req.wdata & LVR_MASK_COMPARATOR_CONTROL; // [RULE12]
         end
      end
      // route to pin needs power, enable bit and the pin as input
      next_state.route = next_state.reference_control[LVR_POS_POWER] // [RULE14]
         && next_state.reference_control[LVR_POS_PIN] // [RULE2]
         && next_state.port_a_direction[LVR_POS_SHARED_PIN]; // [RULE11]
      next_state.cmp_internal = next_state.reference_control[LVR_POS_POWER]
         && (next_state.comparator_control[2:0] == LVR_CMP_MODE_INTERNAL); // [RULE13]
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state.reference_control <= LVR_RESET_REFERENCE_CONTROL; // [RULE8]
         state.port_a_direction <= LVR_RESET_PORT_A_DIRECTION;
         state.comparator_control <= LVR_RESET_COMPARATOR_CONTROL;
         state.rdata <= 8'h00;
         state.route <= 1'b0;
         state.cmp_internal <= 1'b0;
      end else begin
         state <= next_state; // [RULE9]
      end
   end

   lvr_tap_decode #(
      .TAPS(TAPS)
   ) i_lvr_tap_decode (
      .enable(state.reference_control[LVR_POS_POWER]), // [RULE14]
      .range_low(state.reference_control[LVR_POS_RANGE]), // [RULE3]
      .tap_select(state.reference_control[3:0]),
      .tap_onehot(dec_onehot),
      .level_num(dec_num),
      .level_den(dec_den)
   );

   always_comb begin
      ana.power_on = state.reference_control[LVR_POS_POWER]; // [RULE1]
      ana.pin_route = state.route;
      ana.range_low = state.reference_control[LVR_POS_RANGE];
      ana.tap_onehot = dec_onehot;
      ana.level_num = dec_num;
      ana.level_den = dec_den;
      ana.cmp_plus_internal = state.cmp_internal;
   end

   assign reg_rdata = state.rdata;
   assign ladder_power_on = ana.power_on;
   assign ref_to_pin_enable = state.reference_control[LVR_POS_PIN];
   assign range_low_select = ana.range_low;
   assign tap_select = state.reference_control[3:0];
   assign tap_onehot = ana.tap_onehot;
   assign level_num = ana.level_num;
   assign level_den = ana.level_den;
   assign shared_analog_pin_route = ana.pin_route;
   assign shared_pin_direction = state.port_a_direction[LVR_POS_SHARED_PIN];
   assign comparator_plus_internal = ana.cmp_plus_internal;
   assign comparator_mode_field = state.comparator_control[2:0];

   // assertions
   AST_RESET_CLEAR: assert property (@(posedge ref_clk) $fell(rst) |-> // [RULE8]
      (ladder_power_on == 1'b0 && shared_analog_pin_route == 1'b0 && tap_select == 4'h0 && !range_low_select))
      else $error("reference control not cleared by reset");
   AST_BIT4_ZERO: assert property (@(posedge ref_clk) disable iff (rst) // [RULE4]
      $past(reg_rd) && $past(reg_addr) == LVR_ADDR_REFERENCE_CONTROL |-> reg_rdata[4] == 1'b0)
      else $error("unimplemented bit reads nonzero");
   AST_WRITE_POWER: assert property (@(posedge ref_clk) disable iff (rst) // [RULE1]
      reg_wr && reg_addr == LVR_ADDR_REFERENCE_CONTROL |=> ladder_power_on == $past(reg_wdata[7]))
      else $error("power bit did not follow write");
   AST_PIN_ROUTE: assert property (@(posedge ref_clk) disable iff (rst) // [RULE11]
      shared_analog_pin_route |-> (shared_pin_direction && ref_to_pin_enable && ladder_power_on))
      else $error("pin driven without input direction and enable");
   AST_OFF_NO_TAP: assert property (@(posedge ref_clk) disable iff (rst) // [RULE14]
      !ladder_power_on |-> (tap_onehot == '0 && !shared_analog_pin_route))
      else $error("tap or pin active while powered down");
   AST_ONE_TAP: assert property (@(posedge ref_clk) disable iff (rst) // [RULE5]
      ladder_power_on |-> (tap_onehot == (TAPS'(1) << tap_select)))
      else $error("tap select not one-hot");
   AST_LOW_RANGE: assert property (@(posedge ref_clk) disable iff (rst) // [RULE6]
      range_low_select |-> (level_den == 6'h18 && level_num == {2'h0, tap_select}))
      else $error("low range ratio wrong");
   AST_HIGH_RANGE: assert property (@(posedge ref_clk) disable iff (rst) // [RULE7]
      !range_low_select |-> (level_den == 6'h20 && level_num == 6'h08 + {2'h0, tap_select}))
      else $error("high range ratio wrong");
   AST_CMP_ISOLATED: assert property (@(posedge ref_clk) disable iff (rst) // [RULE12]
      reg_wr && reg_addr == LVR_ADDR_COMPARATOR_CONTROL |=> $stable({ladder_power_on, ref_to_pin_enable,
      range_low_select, tap_select}))
      else $error("comparator write changed reference control");
   AST_WAKE_HOLD: assert property (@(posedge ref_clk) disable iff (rst) // [RULE9]
      sleep_wake && !reg_wr |=> $stable({ladder_power_on, ref_to_pin_enable, range_low_select, tap_select}))
      else $error("wake changed reference control");
   AST_CMP_MODE: assert property (@(posedge ref_clk) disable iff (rst) // [RULE13]
      comparator_plus_internal == (ladder_power_on && comparator_mode_field == 3'h2))
      else $error("comparator routing wrong");
   AST_PIN_BIT: assert property (@(posedge ref_clk) disable iff (rst) // [RULE2]
      (ladder_power_on && shared_pin_direction && ref_to_pin_enable) |-> shared_analog_pin_route)
      else $error("pin not routed when enabled");

   // bus steps named once, so each property reads as cause then effect
   sequence s_ref_write;
      reg_wr && (reg_addr == LVR_ADDR_REFERENCE_CONTROL);
   endsequence
   sequence s_dir_write;
      reg_wr && (reg_addr == LVR_ADDR_PORT_A_DIRECTION);
   endsequence
   sequence s_cmp_write;
      reg_wr && (reg_addr == LVR_ADDR_COMPARATOR_CONTROL);
   endsequence
   sequence s_ref_read;
      reg_rd && (reg_addr == LVR_ADDR_REFERENCE_CONTROL);
   endsequence
   sequence s_other_write;
      reg_wr && (reg_addr != LVR_ADDR_REFERENCE_CONTROL) && (reg_addr != LVR_ADDR_PORT_A_DIRECTION)
         && (reg_addr != LVR_ADDR_COMPARATOR_CONTROL);
   endsequence
   // read data stand one cycle only, so a late sampler sees zero, not stale data
   sequence s_read_then_quiet;
      reg_rd ##1 !reg_rd;
   endsequence
   sequence s_power_off_write;
      s_ref_write ##0 !reg_wdata[LVR_POS_POWER];
   endsequence
   sequence s_power_on_write;
      s_ref_write ##0 reg_wdata[LVR_POS_POWER];
   endsequence
   sequence s_dir_output_write;
      s_dir_write ##0 !reg_wdata[LVR_POS_SHARED_PIN];
   endsequence
   sequence s_cmp_internal_write;
      s_cmp_write ##0 (reg_wdata[2:0] == LVR_CMP_MODE_INTERNAL) ##0 ladder_power_on;
   endsequence

   property p_write_pin;
      @(posedge ref_clk) disable iff (rst)
      s_ref_write |=> ref_to_pin_enable == $past(reg_wdata[LVR_POS_PIN]);
   endproperty
   AST_WRITE_PIN: assert property (p_write_pin) // [RULE2]
      else $error("pin enable bit did not follow write");

   property p_write_range;
      @(posedge ref_clk) disable iff (rst)
      s_ref_write |=> range_low_select == $past(reg_wdata[LVR_POS_RANGE]);
   endproperty
   AST_WRITE_RANGE: assert property (p_write_range) // [RULE3]
      else $error("range bit did not follow write");

   property p_write_tap;
      @(posedge ref_clk) disable iff (rst)
      s_ref_write |=> tap_select == $past(reg_wdata[3:0]);
   endproperty
   AST_WRITE_TAP: assert property (p_write_tap) // [RULE5]
      else $error("tap select did not follow write");

   property p_ref_readback;
      @(posedge ref_clk) disable iff (rst)
      s_ref_read |=> reg_rdata == {ladder_power_on, ref_to_pin_enable, range_low_select, 1'b0, tap_select};
   endproperty
   AST_REF_READBACK: assert property (p_ref_readback) // [RULE4]
      else $error("reference control read back wrong");

   property p_rdata_quiet;
      @(posedge ref_clk) disable iff (rst)
      s_read_then_quiet |=> reg_rdata == 8'h00;
   endproperty
   AST_RDATA_QUIET: assert property (p_rdata_quiet)
      else $error("read data stood too long");

   property p_ref_hold;
      @(posedge ref_clk) disable iff (rst)
      !(reg_wr && (reg_addr == LVR_ADDR_REFERENCE_CONTROL))
         |=> $stable({ladder_power_on, ref_to_pin_enable, range_low_select, tap_select});
   endproperty
   AST_REF_HOLD: assert property (p_ref_hold) // [RULE9]
      else $error("reference control changed without a write");

   property p_other_write;
      @(posedge ref_clk) disable iff (rst)
      s_other_write |=> $stable({ladder_power_on, ref_to_pin_enable, range_low_select, tap_select,
         shared_pin_direction, comparator_mode_field});
   endproperty
   AST_OTHER_WRITE: assert property (p_other_write)
      else $error("unmapped write changed a register");

   property p_dir_write;
      @(posedge ref_clk) disable iff (rst)
      s_dir_write |=> shared_pin_direction == $past(reg_wdata[LVR_POS_SHARED_PIN]);
   endproperty
   AST_DIR_WRITE: assert property (p_dir_write) // [RULE11]
      else $error("direction bit did not follow write");

   property p_dir_drop_route;
      @(posedge ref_clk) disable iff (rst)
      s_dir_output_write |=> !shared_analog_pin_route;
   endproperty
   AST_DIR_DROP_ROUTE: assert property (p_dir_drop_route) // [RULE11]
      else $error("pin still driven after direction set to output");

   property p_power_down;
      @(posedge ref_clk) disable iff (rst)
      s_power_off_write |=> (tap_onehot == '0 && !shared_analog_pin_route && !comparator_plus_internal);
   endproperty
   AST_POWER_DOWN: assert property (p_power_down) // [RULE14]
      else $error("ladder outputs live after power down");

   property p_power_up_tap;
      @(posedge ref_clk) disable iff (rst)
      s_power_on_write |=> ($countones(tap_onehot) == 1 && tap_onehot[tap_select]);
   endproperty
   AST_POWER_UP_TAP: assert property (p_power_up_tap) // [RULE5]
      else $error("no single tap after power up");

   property p_cmp_mode;
      @(posedge ref_clk) disable iff (rst)
      s_cmp_write |=> comparator_mode_field == $past(reg_wdata[2:0]);
   endproperty
   AST_CMP_WRITE_MODE: assert property (p_cmp_mode) // [RULE13]
      else $error("comparator mode did not follow write");

   property p_cmp_route;
      @(posedge ref_clk) disable iff (rst)
      s_cmp_internal_write |=> comparator_plus_internal;
   endproperty
   AST_CMP_ROUTE: assert property (p_cmp_route) // [RULE13]
      else $error("reference not routed to comparators");

   property p_off_no_cmp;
      @(posedge ref_clk) disable iff (rst)
      !ladder_power_on |-> !comparator_plus_internal;
   endproperty
   AST_OFF_NO_CMP: assert property (p_off_no_cmp) // [RULE14]
      else $error("comparators fed from an unpowered ladder");

   property p_reset_state;
      @(posedge ref_clk)
      $fell(rst) |-> (shared_pin_direction && reg_rdata == 8'h00 && comparator_mode_field == 3'h0
         && !comparator_plus_internal);
   endproperty
   AST_RESET_STATE: assert property (p_reset_state)
      else $error("block not in reset state after release");

   // the ladder never reaches the supply, so the ratio stays below one
   property p_level_order;
      @(posedge ref_clk) disable iff (rst)
      level_num < level_den;
   endproperty
   AST_LEVEL_ORDER: assert property (p_level_order) // [RULE6] [RULE7]
      else $error("level ratio not below one");
endmodule
`default_nettype wire

// *** tb/lvr_ladder_model.sv ***
// behavioural ladder: reports supply draw and which tap is closed
`timescale 1ns/100ps
`default_nettype none
module lvr_ladder_model (
   input wire logic power_on,
   input wire logic [15:0] tap_onehot,
   output logic drawing,
   output logic [4:0] tap_index
);
   always_comb begin
      drawing = power_on;
      tap_index = 5'h10;
      for (int i = 0; i < 16; i++) begin
         if (tap_onehot[i]) begin
            tap_index = 5'(i);
         end
      end
   end
endmodule
`default_nettype wire

// *** tb/lvr_ladder_ctrl_tb.sv ***
// self-checking bench of the ladder reference control
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; $display("mismatch %0t got %h exp %h", $time, a, b); end end
module lvr_ladder_ctrl_tb import lvr_pkg::*; ;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic sleep_wake = 1'b0;
   logic [7:0] reg_rdata;
   logic ladder_power_on, ref_to_pin_enable, range_low_select, drawing;
   logic shared_analog_pin_route, shared_pin_direction, comparator_plus_internal;
   logic [3:0] tap_select;
   logic [15:0] tap_onehot;
   logic [5:0] level_num, level_den;
   logic [2:0] comparator_mode_field;
   logic [4:0] tap_index;
   int err_count = 0;
   int compares = 0;
   int cycles = 0;
   lvr_ladder_ctrl i_lvr_ladder_ctrl (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_wake(sleep_wake),
      .ladder_power_on(ladder_power_on), .ref_to_pin_enable(ref_to_pin_enable),
      .range_low_select(range_low_select), .tap_select(tap_select), .tap_onehot(tap_onehot),
      .level_num(level_num), .level_den(level_den), .shared_analog_pin_route(shared_analog_pin_route),
      .shared_pin_direction(shared_pin_direction), .comparator_plus_internal(comparator_plus_internal),
      .comparator_mode_field(comparator_mode_field));
   lvr_ladder_model i_lvr_ladder_model (.power_on(ladder_power_on), .tap_onehot(tap_onehot),
      .drawing(drawing), .tap_index(tap_index));
   always #5 ref_clk = ~ref_clk;
   // ceiling well above the roughly 110 cycles the tests use
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         end_of_test();
      end
   end
   task automatic end_of_test;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      `CHK(reg_rdata, e)
   endtask
   task automatic t_reset;
      rd(LVR_ADDR_REFERENCE_CONTROL, 8'h00);
      rd(LVR_ADDR_PORT_A_DIRECTION, 8'h1F);
      `CHK({ladder_power_on, ref_to_pin_enable, range_low_select, tap_select}, 7'h00)
      `CHK(shared_pin_direction, 1'b1)
      $display("test reset done");
   endtask
   task automatic t_levels;
      for (int r = 0; r < 2; r++) begin
         for (int n = 0; n < 16; n++) begin
            wr(LVR_ADDR_REFERENCE_CONTROL, {2'h2, r[0], 1'b0, n[3:0]});
            `CHK(tap_index, 5'(n))
            `CHK(tap_select, n[3:0])
            `CHK(range_low_select, r[0])
            `CHK(level_num, r[0] ? 6'(n) : 6'(8 + n))
            `CHK(level_den, r[0] ? 6'h18 : 6'h20)
         end
      end
      wr(LVR_ADDR_REFERENCE_CONTROL, 8'hFF);
      rd(LVR_ADDR_REFERENCE_CONTROL, 8'hEF);
      $display("test levels done");
   endtask
   task automatic t_route;
      wr(LVR_ADDR_REFERENCE_CONTROL, 8'hC0);
      `CHK(shared_analog_pin_route, 1'b1)
      wr(LVR_ADDR_PORT_A_DIRECTION, 8'h1B);
      `CHK(shared_analog_pin_route, 1'b0)
      wr(LVR_ADDR_PORT_A_DIRECTION, 8'h04);
      wr(LVR_ADDR_REFERENCE_CONTROL, 8'h45);
      `CHK({shared_analog_pin_route, tap_index, drawing}, 7'h20)
      `CHK(ref_to_pin_enable, 1'b1)
      $display("test route done");
   endtask
   task automatic t_cmp;
      wr(LVR_ADDR_REFERENCE_CONTROL, 8'h83);
      wr(LVR_ADDR_COMPARATOR_CONTROL, 8'hFA);
      `CHK({comparator_mode_field, comparator_plus_internal}, 4'h5)
      rd(LVR_ADDR_REFERENCE_CONTROL, 8'h83);
      rd(LVR_ADDR_COMPARATOR_CONTROL, 8'h0A);
      wr(LVR_ADDR_COMPARATOR_CONTROL, 8'h03);
      `CHK(comparator_plus_internal, 1'b0)
      $display("test comparator done");
   endtask
   task automatic t_sleep_reset;
      // power down first, as software should before sleep
      wr(LVR_ADDR_REFERENCE_CONTROL, 8'h26);
      @(posedge ref_clk);
      sleep_wake <= 1'b1;
      @(posedge ref_clk);
      sleep_wake <= 1'b0;
      wr(8'h50, 8'hFF);
      rd(8'h50, 8'h00);
      rd(LVR_ADDR_REFERENCE_CONTROL, 8'h26);
      wr(LVR_ADDR_REFERENCE_CONTROL, 8'hEF);
      @(posedge ref_clk);
      rst <= 1'b1;
      @(posedge ref_clk);
      rst <= 1'b0;
      rd(LVR_ADDR_REFERENCE_CONTROL, 8'h00);
      $display("test sleep and reset done");
   endtask
   initial begin
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      t_reset();
      t_levels();
      t_route();
      t_cmp();
      t_sleep_reset();
      end_of_test();
   end
endmodule
`default_nettype wire
